// >>> hw/spfc_pkg.sv
// Package: constants for the segment privilege fault checker
package spfc_pkg;
  localparam int unsigned ADDR_W = 32;
  localparam logic [7:0] VEC_UD = 8'h06;
  localparam logic [7:0] VEC_NP = 8'h0b;
  localparam logic [7:0] VEC_SS = 8'h0c;
  localparam logic [7:0] VEC_GP = 8'h0d;
  localparam logic [31:0] REAL_LIMIT = 32'h0000_ffff;
  localparam logic [1:0] PL_MOST = 2'h0;
  // Register offsets (byte addresses)
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_FLAGS = 8'h04;
  localparam logic [7:0] OFS_FAULT = 8'h08;
  localparam logic [7:0] OFS_FADDR = 8'h0c;
  // Field positions
  localparam int unsigned CTRL_PE = 0;
  localparam int unsigned CTRL_CPL = 1;
  localparam int unsigned FLG_IF = 9;
  localparam int unsigned FLG_IO_PRIVILEGE_LEVEL = 12;
  localparam int unsigned FLG_VM = 17;
  localparam int unsigned FLG_ZF = 6;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] FLAGS_RST = 32'h0000_0002;
  // Check request kinds
  typedef enum logic [3:0] {
    spfc_chk_none, spfc_chk_mem, spfc_chk_segload, spfc_chk_far, spfc_chk_near,
    spfc_chk_priv, spfc_chk_io, spfc_chk_popf, spfc_chk_lmsw, spfc_chk_movcr0,
    spfc_chk_verify, spfc_chk_copro, spfc_chk_pmonly, spfc_chk_locked, spfc_chk_desc
  } spfc_kind_type;
  typedef enum logic [2:0] {
    spfc_seg_code, spfc_seg_data, spfc_seg_extra, spfc_seg_stack, spfc_seg_aux_one, spfc_seg_aux_two
  } spfc_seg_type;
endpackage : spfc_pkg

// >>> hw/spfc_checker.sv
// Segment and privilege fault checker with APB view of mode and flags
// How it works
// - Real mode: protected-only instruction raises vector 6
// - Real mode: operand byte past FFFFH in non-stack segment raises 13
// - Real mode: stack operand byte past FFFFH raises 12
// - Designated locking instructions drive bus lock without prefix
// - Bus lock held throughout descriptor table entry accesses
// - Protected: unusable non-stack operand raises 13, stack violation 12
// - Segment load privilege levels must agree, else 13
// - Non-stack segment load with absent descriptor raises 11
// - Stack segment load with absent segment raises 12
// - Far transfer to other code segment violating privilege raises 13
// - Privileged instruction with current level above zero raises 13
// - I/O-sensitive instruction with level above io level raises 13
// - Flags load keeps interrupt enable when level above io level
// - Io level and virtual flag updated only at level zero
// - Status word load sets but never clears protection enable
// - Selector verify privilege violation clears zero flag, no fault
// - Coprocessor operand limit violation outside the stack segment, or rights violation, raises 13 before execution
// - Coprocessor operand start past stack limit raises 12
// - Transfer target past code segment limit raises 13
//
// Our own choices: the APB slave port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module spfc_checker (
  input wire logic core_clk_i,
  input wire logic srst_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Check request from the pipeline
  input wire logic req_valid_i,
  input wire spfc_pkg::spfc_kind_type req_kind_i,
  input wire spfc_pkg::spfc_seg_type req_seg_i,
  input wire logic [31:0] req_eip_i,
  input wire logic [31:0] req_offset_i,
  input wire logic [2:0] req_size_m1_i,
  input wire logic [31:0] req_limit_i,
  input wire logic req_rights_ok_i,
  input wire logic req_present_i,
  input wire logic [1:0] requested_privilege_level_i,
  input wire logic [1:0] descriptor_privilege_level_i,
  input wire logic req_priv_ok_i,
  input wire logic req_other_cs_i,
  input wire logic [31:0] req_wdata_i,
  // Results
  output logic done_o,
  output logic fault_o,
  output logic [7:0] fault_vector_o,
  output logic [31:0] fault_eip_o,
  output logic bus_lock_o,
  output logic protection_enable_bit_o,
  output logic [31:0] flags_o
);
  import spfc_pkg::*;

  logic [31:0] ctrl_q;
  logic [31:0] flags_q;
  logic [31:0] fault_info_q;
  logic [31:0] fault_eip_q;
  logic done_q;
  logic fault_q;
  logic [7:0] vec_q;
  logic lock_q;

  logic pe;
  logic [1:0] current_privilege_level;
  logic [1:0] io_privilege_level;
  assign pe = ctrl_q[CTRL_PE];
  assign current_privilege_level = ctrl_q[CTRL_CPL +: 2];
  assign io_privilege_level = flags_q[FLG_IO_PRIVILEGE_LEVEL +: 2];

  // Last byte of the operand, with carry to catch wrap past 4 GB
  logic [32:0] last_byte;
  logic over_limit;
  logic start_over;
  logic is_stack;
  assign last_byte = {1'b0, req_offset_i} + {30'h0, req_size_m1_i};
  assign is_stack = (req_seg_i == spfc_seg_stack);
  assign start_over = req_offset_i > (pe ? req_limit_i : REAL_LIMIT);
  assign over_limit = last_byte > {1'b0, (pe ? req_limit_i : REAL_LIMIT)};

  // Combinational fault decision
  logic flt;
  logic [7:0] vec;
  always_comb begin
    flt = 1'b0;
    vec = VEC_GP;
    case (req_kind_i)
      spfc_chk_pmonly: begin
        if (!pe) begin
          flt = 1'b1;
          vec = VEC_UD;
        end
      end
      spfc_chk_mem, spfc_chk_locked: begin
        if (over_limit || (pe && !req_rights_ok_i)) begin
          flt = 1'b1;
          vec = is_stack ? VEC_SS : VEC_GP;
        end
      end
      spfc_chk_copro: begin
        if (is_stack && start_over) begin
          flt = 1'b1;
          vec = VEC_SS;
        end else if ((!is_stack && over_limit) || (pe && !req_rights_ok_i)) begin
          flt = 1'b1;
          vec = VEC_GP;
        end
      end
      spfc_chk_segload: begin
        if (pe) begin
          if (!req_priv_ok_i) begin
            flt = 1'b1;
            vec = VEC_GP;
          end else if (!req_present_i && is_stack) begin
            flt = 1'b1;
            vec = VEC_SS;
          end else if (!req_present_i) begin
            flt = 1'b1;
            vec = VEC_NP;
          end
        end
      end
      spfc_chk_far: begin
        if ((pe && req_other_cs_i && !req_priv_ok_i) || start_over) begin
          flt = 1'b1;
          vec = VEC_GP;
        end
      end
      spfc_chk_near: begin
        if (start_over) begin
          flt = 1'b1;
          vec = VEC_GP;
        end
      end
      spfc_chk_priv, spfc_chk_lmsw, spfc_chk_movcr0: begin
        if (pe && current_privilege_level != PL_MOST) begin
          flt = 1'b1;
          vec = VEC_GP;
        end
      end
      spfc_chk_io: begin
        if (pe && current_privilege_level > io_privilege_level) begin
          flt = 1'b1;
          vec = VEC_GP;
        end
      end
      default: begin
        flt = 1'b0;
        vec = VEC_GP;
      end
    endcase
  end

  logic go;
  assign go = req_valid_i && (req_kind_i != spfc_chk_none);

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      done_q <= 1'b0;
      fault_q <= 1'b0;
      vec_q <= 8'h00;
      fault_eip_q <= 32'h0000_0000;
      fault_info_q <= 32'h0000_0000;
    end else begin
      done_q <= go;
      fault_q <= go && flt;
      if (go && flt) begin
        vec_q <= vec;
        fault_eip_q <= req_eip_i;
        fault_info_q <= {24'h00_0000, vec};
      end
    end
  end

  // Bus lock for locked instructions and descriptor accesses
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      lock_q <= 1'b0;
    end else begin
      lock_q <= req_valid_i && (req_kind_i == spfc_chk_desc ||
                (req_kind_i == spfc_chk_locked && !flt));
    end
  end

  // Architectural control: protection enable and current level
  logic apb_wr;
  assign apb_wr = psel_i && penable_i && pwrite_i;
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      ctrl_q <= CTRL_RST;
    end else if (go && !flt && req_kind_i == spfc_chk_lmsw) begin
      ctrl_q[CTRL_PE] <= pe | req_wdata_i[0];
    end else if (go && !flt && req_kind_i == spfc_chk_movcr0) begin
      ctrl_q[CTRL_PE] <= req_wdata_i[0];
    end else if (apb_wr && paddr_i == OFS_CTRL) begin
      ctrl_q <= {29'h0, pwdata_i[2:0]};
    end
  end

  // Flags register
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      flags_q <= FLAGS_RST;
    end else if (go && !flt && req_kind_i == spfc_chk_popf) begin
      flags_q <= req_wdata_i | FLAGS_RST;
      if (pe && current_privilege_level > io_privilege_level) begin
        flags_q[FLG_IF] <= flags_q[FLG_IF];
      end
      // keep io level and virtual flag
      if (pe && current_privilege_level != PL_MOST) begin
        flags_q[FLG_IO_PRIVILEGE_LEVEL +: 2] <= flags_q[FLG_IO_PRIVILEGE_LEVEL +: 2];
        flags_q[FLG_VM] <= flags_q[FLG_VM];
      end
    end else if (go && req_kind_i == spfc_chk_verify) begin
      flags_q[FLG_ZF] <= req_priv_ok_i && req_rights_ok_i;
    end else if (apb_wr && paddr_i == OFS_FLAGS) begin
      flags_q <= pwdata_i | FLAGS_RST;
    end
  end

  // APB read
  logic [31:0] rd;
  logic mapped;
  always_comb begin
    rd = 32'h0000_0000;
    mapped = 1'b1;
    case (paddr_i)
      OFS_CTRL: rd = ctrl_q;
      OFS_FLAGS: rd = flags_q;
      OFS_FAULT: rd = fault_info_q;
      OFS_FADDR: rd = fault_eip_q;
      default: mapped = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      prdata_o <= 32'h0000_0000;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end else begin
      pready_o <= psel_i && !penable_i;
      pslverr_o <= psel_i && !penable_i && !mapped;
      prdata_o <= (psel_i && !penable_i && !pwrite_i) ? rd : 32'h0000_0000;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      done_o <= 1'b0;
      fault_o <= 1'b0;
      fault_vector_o <= 8'h00;
      fault_eip_o <= 32'h0000_0000;
      bus_lock_o <= 1'b0;
      protection_enable_bit_o <= 1'b0;
      flags_o <= FLAGS_RST;
    end else begin
      done_o <= done_q;
      fault_o <= fault_q;
      fault_vector_o <= vec_q;
      fault_eip_o <= fault_eip_q;
      bus_lock_o <= lock_q;
      protection_enable_bit_o <= ctrl_q[CTRL_PE];
      flags_o <= flags_q;
    end
  end

  // Assertions
  property p_gp_real;
    @(posedge core_clk_i) disable iff (srst_i)
      (req_valid_i && !pe && req_kind_i == spfc_chk_mem && !is_stack && over_limit)
        |=> ##1 (fault_o && fault_vector_o == VEC_GP);
  endproperty
  real_gp_a: assert property (p_gp_real) else $error("real mode limit not 13");
  real_ss_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (req_valid_i && req_kind_i == spfc_chk_mem && is_stack && over_limit)
      |-> ##2 (fault_o && fault_vector_o == VEC_SS)) else $error("stack limit not 12");
  real_ud_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (req_valid_i && !pe && req_kind_i == spfc_chk_pmonly) |-> ##2 (fault_vector_o == VEC_UD))
    else $error("real mode opcode not 6");
  np_vec_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (req_valid_i && pe && req_kind_i == spfc_chk_segload && req_priv_ok_i && !req_present_i)
      |-> ##2 (fault_vector_o == (is_stack ? VEC_SS : VEC_NP))) else $error("not present vector");
  priv_gp_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (req_valid_i && pe && req_kind_i == spfc_chk_priv && current_privilege_level != PL_MOST) |-> ##2 fault_o)
    else $error("privileged op missed");
  io_gp_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (req_valid_i && pe && req_kind_i == spfc_chk_io) |-> ##2 (fault_o == (current_privilege_level > io_privilege_level)))
    else $error("io privilege check");
  pe_sticky_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (req_valid_i && req_kind_i == spfc_chk_lmsw && pe) |=> pe) else $error("status word cleared pe");
  lock_desc_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (req_valid_i && req_kind_i == spfc_chk_desc) |-> ##2 bus_lock_o) else $error("no lock on desc");
  if_keep_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (req_valid_i && pe && req_kind_i == spfc_chk_popf && current_privilege_level > io_privilege_level && !apb_wr)
      |=> $stable(flags_q[FLG_IF])) else $error("interrupt flag changed");
  verify_nf_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (req_valid_i && req_kind_i == spfc_chk_verify) |-> ##2 !fault_o) else $error("verify faulted");

  // Protected-mode operand checks
  pm_gp_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (req_valid_i && pe && req_kind_i == spfc_chk_mem && !is_stack && (over_limit || !req_rights_ok_i))
      |-> ##2 (fault_o && fault_vector_o == VEC_GP))
    else $error("unusable operand not 13");
  pm_ss_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (req_valid_i && pe && req_kind_i == spfc_chk_mem && is_stack && over_limit)
      |-> ##2 (fault_o && fault_vector_o == VEC_SS))
    else $error("stack limit not 12");

  // Segment loads and transfers
  seg_priv_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (req_valid_i && pe && req_kind_i == spfc_chk_segload && !req_priv_ok_i)
      |-> ##2 (fault_o && fault_vector_o == VEC_GP))
    else $error("segment load privilege not 13");
  far_priv_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (req_valid_i && pe && req_kind_i == spfc_chk_far && req_other_cs_i && !req_priv_ok_i)
      |-> ##2 (fault_o && fault_vector_o == VEC_GP))
    else $error("far transfer privilege not 13");
  target_lim_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (req_valid_i && (req_kind_i == spfc_chk_near || req_kind_i == spfc_chk_far) && start_over)
      |-> ##2 (fault_o && fault_vector_o == VEC_GP))
    else $error("transfer target limit not 13");

  // Coprocessor operand checks
  copro_ss_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (req_valid_i && req_kind_i == spfc_chk_copro && is_stack && start_over)
      |-> ##2 (fault_o && fault_vector_o == VEC_SS))
    else $error("coprocessor stack start not 12");
  copro_gp_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (req_valid_i && req_kind_i == spfc_chk_copro && !is_stack && over_limit)
      |-> ##2 (fault_o && fault_vector_o == VEC_GP))
    else $error("coprocessor operand not 13");

  // Locked instruction drives the lock with no prefix input at all
  lock_inst_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (req_valid_i && req_kind_i == spfc_chk_locked && !over_limit && (!pe || req_rights_ok_i))
      |-> ##2 bus_lock_o)
    else $error("no lock on locked instruction");

  // Flags image load above level zero
  io_privilege_level_keep_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (req_valid_i && pe && req_kind_i == spfc_chk_popf && current_privilege_level != PL_MOST && !apb_wr)
      |=> ($stable(flags_q[FLG_IO_PRIVILEGE_LEVEL +: 2]) && $stable(flags_q[FLG_VM])))
    else $error("io level or virtual flag changed");

  // Fault report and completion pulse
  eip_report_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (req_valid_i && !pe && req_kind_i == spfc_chk_pmonly)
      |-> ##2 (fault_eip_o == $past(req_eip_i, 2)))
    else $error("restart address not reported");
  done_pulse_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (req_valid_i && req_kind_i != spfc_chk_none) |-> ##2 done_o)
    else $error("request not completed");
  fault_done_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
    fault_o |-> done_o)
    else $error("fault without done");

  // Ready stands for one cycle only
  apb_ready_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
    pready_o |=> !pready_o)
    else $error("ready stood two cycles");
endmodule : spfc_checker
`default_nettype wire

// >>> verification/spfc_pipe_model.sv
// Pipeline model that issues check requests
`timescale 1ns/100ps
`default_nettype none
module spfc_pipe_model (
  input wire logic core_clk_i,
  output logic valid_o,
  output var spfc_pkg::spfc_kind_type kind_o,
  output var spfc_pkg::spfc_seg_type seg_o,
  output logic [31:0] eip_o,
  output logic [31:0] off_o,
  output logic [2:0] size_m1_o,
  output logic [31:0] limit_o,
  output logic [3:0] res_o,
  output logic [31:0] wdata_o
);
  import spfc_pkg::*;
  initial begin
    valid_o = 1'b0;
    kind_o = spfc_chk_none;
    seg_o = spfc_seg_data;
    {eip_o, off_o, limit_o, wdata_o, size_m1_o, res_o} = '0;
  end
  // One request, held for exactly one taken edge
  task automatic send(input spfc_kind_type k, input spfc_seg_type s, input logic [31:0] o,
                      input logic [2:0] z, input logic [31:0] l, input logic [3:0] f);
    @(posedge core_clk_i);
    valid_o <= 1'b1;
    kind_o <= k;
    seg_o <= s;
    eip_o <= ~o;
    off_o <= o;
    wdata_o <= o;
    size_m1_o <= z;
    limit_o <= l;
    res_o <= f;
    @(posedge core_clk_i);
    // Released offset, write data and limit lines show the inverse so stale values are not mistaken for live ones
    valid_o <= 1'b0;
    kind_o <= spfc_chk_none;
    off_o <= ~o;
    wdata_o <= ~o;
    limit_o <= ~l;
  endtask : send
endmodule : spfc_pipe_model
`default_nettype wire

// >>> verification/tb_spfc_checker.sv
// Self-checking testbench for the segment privilege fault checker
`timescale 1ns/100ps
`default_nettype none
module tb_spfc_checker;
  import spfc_pkg::*;
  localparam logic [3:0] ok = 4'b1110;
  localparam logic [31:0] lim = 32'h0000_0100;
  localparam spfc_seg_type sd = spfc_seg_data;
  localparam spfc_seg_type ss = spfc_seg_stack;
  logic core_clk_i, srst_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, req_valid_i;
  logic done_o, fault_o, bus_lock_o, protection_enable_bit_o, re;
  logic [7:0] paddr_i, fault_vector_o;
  logic [31:0] pwdata_i, prdata_o, req_eip_i, req_offset_i, req_limit_i, req_wdata_i, fault_eip_o, flags_o, rq;
  logic [2:0] req_size_m1_i;
  logic [3:0] res;
  spfc_kind_type req_kind_i;
  spfc_seg_type req_seg_i;
  int errors, checks;
  spfc_checker i_spfc_checker (.core_clk_i, .srst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
    .prdata_o, .pready_o, .pslverr_o, .req_valid_i, .req_kind_i, .req_seg_i, .req_eip_i, .req_offset_i,
    .req_size_m1_i, .req_limit_i, .req_rights_ok_i(res[3]), .req_present_i(res[2]), .req_priv_ok_i(res[1]),
    .req_other_cs_i(res[0]), .requested_privilege_level_i(2'h3), .descriptor_privilege_level_i(2'h0),
    .req_wdata_i, .done_o, .fault_o, .fault_vector_o, .fault_eip_o, .bus_lock_o, .protection_enable_bit_o,
    .flags_o);
  spfc_pipe_model i_spfc_pipe_model (.core_clk_i, .valid_o(req_valid_i), .kind_o(req_kind_i),
    .seg_o(req_seg_i), .eip_o(req_eip_i), .off_o(req_offset_i), .size_m1_o(req_size_m1_i),
    .limit_o(req_limit_i), .res_o(res), .wdata_o(req_wdata_i));
  initial begin
    core_clk_i = 1'b0;
    forever #2.5 core_clk_i = ~core_clk_i;
  end
  task automatic close_out();
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : close_out
  task automatic cmp(input logic [31:0] g, input logic [31:0] x);
    checks++;
    if (g !== x) begin
      errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, g, x);
    end
  endtask : cmp
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge core_clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge core_clk_i);
    penable_i <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 50);
    rq = prdata_o;
    re = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    if (n >= 50) errors++;
  endtask : apb
  // Request, then look at the pulse one edge after it was taken; v of zero means no fault
  task automatic chk(input spfc_kind_type k, input spfc_seg_type s, input logic [31:0] o, input logic [2:0] z,
                     input logic [31:0] l, input logic [3:0] f, input logic [7:0] v);
    i_spfc_pipe_model.send(k, s, o, z, l, f);
    repeat (1) @(posedge core_clk_i);
    #1;
    cmp({29'h0, done_o, fault_o, bus_lock_o}, {29'h0, 1'b1, v != 8'h00, k == spfc_chk_desc || (k == spfc_chk_locked && v == 8'h00)});
    if (v != 8'h00) cmp({24'h0, fault_vector_o}, {24'h0, v});
    if (v != 8'h00) cmp(fault_eip_o, ~o);
  endtask : chk
  // Compares virtual flag, io level, interrupt enable and zero flag
  task automatic fl(input logic [4:0] x);
    cmp({27'h0, flags_o[17], flags_o[13:12], flags_o[9], flags_o[6]}, {27'h0, x});
  endtask : fl
  initial begin
    #20000;
    errors++;
    close_out();
  end
  initial begin
    {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = '0;
    srst_i = 1'b1;
    repeat (3) @(posedge core_clk_i);
    srst_i <= 1'b0;
    apb(1'b0, OFS_FLAGS, 32'h0);
    cmp(rq, FLAGS_RST);
    apb(1'b0, 8'h10, 32'h0);
    cmp({re, rq}, {1'b1, 32'h0});
    chk(spfc_chk_pmonly, sd, 32'h0, 3'h0, lim, ok, VEC_UD);
    chk(spfc_chk_mem, sd, 32'h0000_ffff, 3'h0, lim, ok, 8'h00);
    chk(spfc_chk_mem, sd, 32'h0000_ffff, 3'h1, lim, ok, VEC_GP);
    chk(spfc_chk_mem, spfc_seg_extra, 32'h0000_fffd, 3'h3, lim, ok, VEC_GP);
    chk(spfc_chk_mem, ss, 32'h0000_ffff, 3'h3, lim, ok, VEC_SS);
    chk(spfc_chk_locked, sd, 32'h10, 3'h0, lim, ok, 8'h00);
    chk(spfc_chk_desc, sd, 32'h10, 3'h0, lim, ok, 8'h00);
    chk(spfc_chk_lmsw, sd, 32'h1, 3'h0, lim, ok, 8'h00);
    cmp({31'h0, protection_enable_bit_o}, 32'h1);
    chk(spfc_chk_lmsw, sd, 32'h0, 3'h0, lim, ok, 8'h00);
    cmp({31'h0, protection_enable_bit_o}, 32'h1);
    chk(spfc_chk_movcr0, sd, 32'h0, 3'h0, lim, ok, 8'h00);
    cmp({31'h0, protection_enable_bit_o}, 32'h0);
    chk(spfc_chk_movcr0, sd, 32'h1, 3'h0, lim, ok, 8'h00);
    chk(spfc_chk_mem, sd, 32'h10, 3'h3, lim, 4'b0110, VEC_GP);
    chk(spfc_chk_mem, ss, 32'hfe, 3'h3, lim, ok, VEC_SS);
    chk(spfc_chk_segload, sd, 32'h8, 3'h0, lim, 4'b1010, VEC_NP);
    chk(spfc_chk_segload, ss, 32'h8, 3'h0, lim, 4'b1010, VEC_SS);
    chk(spfc_chk_segload, sd, 32'h8, 3'h0, lim, 4'b1100, VEC_GP);
    chk(spfc_chk_far, spfc_seg_code, 32'h20, 3'h0, lim, 4'b1101, VEC_GP);
    chk(spfc_chk_far, spfc_seg_code, 32'h101, 3'h0, lim, 4'b1111, VEC_GP);
    chk(spfc_chk_near, spfc_seg_code, 32'h100, 3'h0, lim, ok, 8'h00);
    chk(spfc_chk_copro, sd, 32'h10, 3'h3, lim, 4'b0110, VEC_GP);
    chk(spfc_chk_copro, ss, 32'h101, 3'h0, lim, ok, VEC_SS);
    chk(spfc_chk_copro, ss, 32'hff, 3'h3, lim, ok, 8'h00);
    chk(spfc_chk_verify, sd, 32'h8, 3'h0, lim, ok, 8'h00);
    fl(5'b00001);
    chk(spfc_chk_verify, sd, 32'h8, 3'h0, lim, 4'b1100, 8'h00);
    fl(5'b00000);
    chk(spfc_chk_popf, sd, 32'h0002_3202, 3'h0, lim, ok, 8'h00);
    fl(5'b11110);
    chk(spfc_chk_popf, sd, 32'h2, 3'h0, lim, ok, 8'h00);
    chk(spfc_chk_priv, sd, 32'h0, 3'h0, lim, ok, 8'h00);
    apb(1'b1, OFS_CTRL, 32'h0000_0007);
    chk(spfc_chk_priv, sd, 32'h4, 3'h0, lim, ok, VEC_GP);
    chk(spfc_chk_io, sd, 32'h4, 3'h0, lim, ok, VEC_GP);
    chk(spfc_chk_popf, sd, 32'h0002_3242, 3'h0, lim, ok, 8'h00);
    fl(5'b00001);
    close_out();
  end
endmodule : tb_spfc_checker
`default_nettype wire
